// file: shared/hfci_pkg.sv
// constants, fields and carriers of the buffer and checksum unit;
// assumes 8-bit register data and a 4-bit register address.
package hfci_pkg;

  // ------------------------------
  // register offsets
  // ------------------------------
  localparam logic [3:0] OFS_CONFIG     = 4'h0; // general_config_reg
  localparam logic [3:0] OFS_EVENT      = 4'h1; // event_flag_reg
  localparam logic [3:0] OFS_IRQ_EN     = 4'h2; // irq_enable_reg
  localparam logic [3:0] OFS_MISC_EVENT = 4'h3; // misc_event_flag_reg
  localparam logic [3:0] OFS_FAULT      = 4'h4; // fault_reg
  localparam logic [3:0] OFS_BUF_PORT   = 4'h5; // buffer_port_reg
  localparam logic [3:0] OFS_BUF_COUNT  = 4'h6; // buffer_count_reg
  localparam logic [3:0] OFS_THRESHOLD  = 4'h7; // threshold_reg
  localparam logic [3:0] OFS_STATE      = 4'h8; // primary_state_reg
  localparam logic [3:0] OFS_CRC_HI     = 4'h9; // checksum_result_reg high
  localparam logic [3:0] OFS_CRC_LO     = 4'hA; // checksum_result_reg low
  localparam logic [3:0] OFS_LEN_LOW    = 4'hB; // length_check_low_reg
  localparam logic [3:0] OFS_LEN_HIGH   = 4'hC; // length_check_high_reg
  localparam logic [3:0] OFS_CRC_CTRL   = 4'hD; // checksum start
  localparam logic [3:0] OFS_MISC_EN    = 4'hE; // misc event enables

  // ------------------------------
  // field positions
  // ------------------------------
  localparam int BIT_MSB_FIRST   = 7; // config: high_bit_leading
  localparam int BIT_CLEAR       = 7; // buffer_count_reg: buffer_clear
  localparam int BIT_CRC_START   = 0; // checksum control
  localparam int BIT_OVERRUN     = 4; // fault_reg: buffer_overrun_flag
  localparam int BIT_ST_NEAR_E   = 0; // primary_state_reg
  localparam int BIT_ST_NEAR_F   = 1;
  localparam int BIT_ST_CRC_FIN  = 5;
  localparam int BIT_ST_IRQ      = 4;
  localparam int BIT_CRC_FLAG    = 2; // misc_event_flag_reg

  // event_flag_reg / irq_enable_reg bit layout
  localparam int EV_TIMER = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_NEAR_E = 2;
  localparam int EV_NEAR_F = 3;
  localparam int EV_IDLE = 4;
  localparam int EV_RX = 5;
  localparam int EV_TX = 6;

  // ------------------------------
  // reset values and checksum constants
  // ------------------------------
  localparam logic [7:0]  RST_CONFIG    = 8'h00;
  localparam logic [5:0]  RST_THRESHOLD = 6'h08;
  localparam logic [5:0]  RST_LEN       = 6'h00;
  localparam logic [15:0] CRC_PRESET0   = 16'h0000;
  localparam logic [15:0] CRC_PRESET1   = 16'h6363;
  localparam logic [15:0] CRC_PRESET2   = 16'hA671;
  localparam logic [15:0] CRC_PRESET3   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_MSB  = 16'h1021; // x^16+x^12+x^5+1
  localparam logic [15:0] CRC_POLY_LSB  = 16'h8408; // same, bit-reversed
  localparam logic [8:0]  LEN_NO_LIMIT  = 9'h100;   // max setting of zero

  // ------------------------------
  // types
  // ------------------------------
  typedef enum logic [0:0] {
    CRC_IDLE = 1'b0,
    CRC_RUN  = 1'b1
  } hfci_crc_e;

  typedef struct packed {
    logic timer_zero; // counter went from 1 to 0
    logic tx_done;    // data to end-of-frame transition
    logic cmd_idle;   // command returned to idle
  } hfci_ev_s;

  typedef struct packed {
    logic       valid; // one received byte
    logic       first; // this byte is the length byte
    logic       done;  // end of received data, no byte
    logic [7:0] data;
  } hfci_rx_s;

endpackage : hfci_pkg

// file: design/hfci_top.sv
// byte buffer, checksum engine, length screening and event flags;
// assumes a strobe-port master and a receiver that never raises
// valid and done together.
//
// Function
// - accept only if length byte >= minimum x4.
// - accept only if length < maximum x4; zero means 256.
// - rejected packet skips buffer; receiver stays on.
// - checksum preset chosen by a two-bit field.
// - polynomial x^16+x^12+x^5+1; high and low bytes.
// - leading-bit setting picks msb or lsb first.
// - host write pushes, host read pops a byte.
// - seven-bit fill count is the pointer distance.
// - one buffer; host keeps off while engine runs.
// - clear resets pointers and count; overrun too, unless a write is lost in that cycle.
// - only the clear bit clears overrun.
// - near-full: 64-fill <= threshold; near-empty: fill <= it.
// - enabled near-full/empty rise raises irq.
// - enabled events show in status bit and irq.
// - countdown flag on timer going one to zero.
// - send-done flag on entering end-of-frame.
// - checksum-done flag with finished bit when drained.
// - receive-done flag at end of received data.
// - command-finished flag when command returns idle.
// - near flags set when status bits rise.
// - fault flag when any fault bit rises.
// - accepted packet: length byte first, error byte last.
//
// Design decisions made here: strobed register access and the address map.
module hfci_top #(
  parameter int DEPTH = 64 // buffer entries
) (
  input  wire logic              clk,      // system clock
  input  wire logic              rst,      // synchronous reset, high
  input  wire logic [3:0]        addr,     // register address
  input  wire logic [7:0]        wdata,    // register write data
  input  wire logic              we,       // write strobe
  input  wire logic              re,       // read strobe
  output logic [7:0]             rdata,    // read data, cycle after re
  input  wire hfci_pkg::hfci_ev_s ev,      // event pulses from the core
  input  wire logic [7:0]        fault_in, // transfer error bits, level
  input  wire hfci_pkg::hfci_rx_s rx,      // received bytes
  output logic                   pkt_drop, // packet rejected, pulse
  output logic                   irq       // interrupt request, high
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [6:0] DEPTH_C = 7'(DEPTH);

  // ------------------------------
  // elaboration check
  // ------------------------------
  // seven-bit count and alert math assume 64 entries
  if (DEPTH != 64) begin : g_bad_depth
    $error("hfci_top: DEPTH must be 64");
  end

  // ------------------------------
  // functions
  // ------------------------------
  // one byte through the checksum, either bit order
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d,
                                           input logic        msb);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (msb) begin
        fb = r[15] ^ d[7-i];
        r  = {r[14:0], 1'b0};
        if (fb) r = r ^ hfci_pkg::CRC_POLY_MSB;
      end else begin
        fb = r[0] ^ d[i];
        r  = {1'b0, r[15:1]};
        if (fb) r = r ^ hfci_pkg::CRC_POLY_LSB;
      end
    end
    return r;
  endfunction : crc_byte

  // preset selection
  function automatic logic [15:0] crc_preset(input logic [1:0] sel);
    logic [15:0] p;
    unique case (sel)
      2'h0: p = hfci_pkg::CRC_PRESET0;
      2'h1: p = hfci_pkg::CRC_PRESET1;
      2'h2: p = hfci_pkg::CRC_PRESET2;
      2'h3: p = hfci_pkg::CRC_PRESET3;
    endcase
    return p;
  endfunction : crc_preset

  // length byte screening
  function automatic logic len_ok(input logic [7:0] len,
                                  input logic [5:0] mn,
                                  input logic [5:0] mx);
    logic [8:0] lo;
    logic [8:0] hi;
    lo = {1'b0, mn, 2'h0};
    hi = (mx == 6'h00) ? hfci_pkg::LEN_NO_LIMIT : {1'b0, mx, 2'h0};
    return ({1'b0, len} >= lo) && ({1'b0, len} < hi);
  endfunction : len_ok

  // ------------------------------
  // state
  // ------------------------------
  logic [7:0]        mem_q [DEPTH];
  logic [PW:0]       wp_q;
  logic [PW:0]       rp_q;
  logic              ovf_q;
  logic [7:0]        config_q;
  logic [5:0]        thr_q;
  logic [5:0]        len_min_q;
  logic [5:0]        len_max_q;
  logic [6:0]        ev_flag_q;
  logic [6:0]        ev_en_q;
  logic              crc_flag_q;
  logic              crc_en_q;
  logic [15:0]       crc_q;
  logic              crc_fin_q;
  hfci_pkg::hfci_crc_e crc_st_q;
  logic              acc_q;
  logic              near_f_prev_q;
  logic              near_e_prev_q;
  logic [7:0]        fault_prev_q;
  logic [7:0]        rdata_q;
  logic              drop_q;
  logic              irq_q;

  // ------------------------------
  // decode and buffer arbitration
  // ------------------------------
  logic [6:0] count;
  logic       full;
  logic       empty;
  logic       busy;
  logic       flush;
  logic       rx_wr;
  logic [7:0] rx_wdat;
  logic       host_wr;
  logic       push;
  logic       do_push;
  logic       host_pop;
  logic       crc_pop;
  logic       pop;
  logic [7:0] fault_img;
  logic       near_f;
  logic       near_e;
  logic       rx_len_pass;

  // extra pointer bit tells full from empty
  assign count = 7'(wp_q - rp_q);
  assign full  = (count == DEPTH_C);
  assign empty = (count == 7'h00);
  assign busy  = (crc_st_q == hfci_pkg::CRC_RUN);
  assign flush = we && (addr == hfci_pkg::OFS_BUF_COUNT)
                 && wdata[hfci_pkg::BIT_CLEAR];
  assign fault_img = {fault_in[7:5], ovf_q, fault_in[3:0]};

  // receiver push decided at the length byte
  assign rx_len_pass = len_ok(rx.data, len_min_q, len_max_q);
  assign rx_wr   = (rx.valid && (rx.first ? rx_len_pass : acc_q))
                   || (rx.done && acc_q);
  assign rx_wdat = rx.done ? fault_img : rx.data;

  // host loses to engine and receiver
  assign host_wr  = we && (addr == hfci_pkg::OFS_BUF_PORT) && !busy
                    && !rx_wr;
  assign push     = rx_wr || host_wr;
  assign do_push  = push && !full;
  assign host_pop = re && (addr == hfci_pkg::OFS_BUF_PORT) && !busy
                    && !empty;
  assign crc_pop  = busy && !empty;
  assign pop      = host_pop || crc_pop;

  // watermark comparisons, both kept in seven bits
  assign near_f = ((DEPTH_C - count) <= {1'b0, thr_q});
  assign near_e = (count <= {1'b0, thr_q});

  // ------------------------------
  // buffer storage and pointers
  // ------------------------------
  // no reset: stale bytes sit behind the pointers
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wp_q[PW-1:0]] <= host_wr ? wdata : rx_wdat;
    end
  end

  // pointers; clear takes priority over a same-cycle push or pop
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (pop)     rp_q <= rp_q + 1'b1;
    end
  end

  // overrun: a lost write beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (push && full) begin
      ovf_q <= 1'b1;
    end else if (flush) begin
      ovf_q <= 1'b0;
    end
  end

  // ------------------------------
  // configuration registers
  // ------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      config_q  <= hfci_pkg::RST_CONFIG;
      thr_q     <= hfci_pkg::RST_THRESHOLD;
      len_min_q <= hfci_pkg::RST_LEN;
      len_max_q <= hfci_pkg::RST_LEN;
      ev_en_q   <= 7'h00;
      crc_en_q  <= 1'b0;
    end else if (we) begin
      unique case (addr)
        hfci_pkg::OFS_CONFIG:    config_q  <= wdata;
        hfci_pkg::OFS_THRESHOLD: thr_q     <= wdata[5:0];
        hfci_pkg::OFS_LEN_LOW:   len_min_q <= wdata[5:0];
        hfci_pkg::OFS_LEN_HIGH:  len_max_q <= wdata[5:0];
        hfci_pkg::OFS_IRQ_EN:    ev_en_q   <= wdata[6:0];
        hfci_pkg::OFS_MISC_EN:   crc_en_q  <= wdata[hfci_pkg::BIT_CRC_FLAG];
        default: ;
      endcase
    end
  end

  // ------------------------------
  // length screening
  // ------------------------------
  // a reject drops bytes only; receiver runs on
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q  <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      drop_q <= rx.valid && rx.first && !rx_len_pass;
      if (rx.valid && rx.first) begin
        acc_q <= rx_len_pass;
      end else if (rx.done) begin
        acc_q <= 1'b0;
      end
    end
  end

  // ------------------------------
  // checksum coprocessor
  // ------------------------------
  // one byte a cycle; the engine drains what it checks
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_st_q  <= hfci_pkg::CRC_IDLE;
      crc_q     <= hfci_pkg::CRC_PRESET0;
      crc_fin_q <= 1'b0;
    end else begin
      unique case (crc_st_q)
        hfci_pkg::CRC_IDLE: begin
          if (we && (addr == hfci_pkg::OFS_CRC_CTRL)
              && wdata[hfci_pkg::BIT_CRC_START]) begin
            crc_q     <= crc_preset(config_q[1:0]);
            crc_fin_q <= 1'b0;
            crc_st_q  <= hfci_pkg::CRC_RUN;
          end
        end
        hfci_pkg::CRC_RUN: begin
          if (empty) begin
            crc_fin_q <= 1'b1;
            crc_st_q  <= hfci_pkg::CRC_IDLE;
          end else begin
            crc_q <= crc_byte(crc_q, mem_q[rp_q[PW-1:0]],
                              config_q[hfci_pkg::BIT_MSB_FIRST]);
          end
        end
      endcase
    end
  end

  // ------------------------------
  // event flags
  // ------------------------------
  logic [6:0] ev_set;
  logic [6:0] ev_clr;
  logic       crc_set;
  logic       crc_clr;

  // edges, so a level never re-raises a cleared flag
  always_ff @(posedge clk) begin
    if (rst) begin
      near_f_prev_q <= 1'b0;
      near_e_prev_q <= 1'b0;
      fault_prev_q  <= 8'h00;
    end else begin
      near_f_prev_q <= near_f;
      near_e_prev_q <= near_e;
      fault_prev_q  <= fault_img;
    end
  end

  // set sources, and write-one-to-clear from the host
  always_comb begin
    ev_set = 7'h00;
    ev_set[hfci_pkg::EV_TIMER]  = ev.timer_zero;
    ev_set[hfci_pkg::EV_TX]     = ev.tx_done;
    ev_set[hfci_pkg::EV_RX]     = rx.done;
    ev_set[hfci_pkg::EV_IDLE]   = ev.cmd_idle;
    ev_set[hfci_pkg::EV_NEAR_F] = near_f && !near_f_prev_q;
    ev_set[hfci_pkg::EV_NEAR_E] = near_e && !near_e_prev_q;
    ev_set[hfci_pkg::EV_FAULT]  = |(fault_img & ~fault_prev_q);
    ev_clr  = (we && addr == hfci_pkg::OFS_EVENT) ? wdata[6:0] : 7'h00;
    crc_set = busy && empty;
    crc_clr = we && (addr == hfci_pkg::OFS_MISC_EVENT)
              && wdata[hfci_pkg::BIT_CRC_FLAG];
  end

  // sticky until cleared; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_flag_q  <= 7'h00;
      crc_flag_q <= 1'b0;
    end else begin
      ev_flag_q  <= (ev_flag_q & ~ev_clr) | ev_set;
      crc_flag_q <= (crc_flag_q && !crc_clr) || crc_set;
    end
  end

  // pin follows any enabled pending flag
  logic irq_any;
  assign irq_any = |(ev_flag_q & ev_en_q) || (crc_flag_q && crc_en_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_any;
    end
  end

  // ------------------------------
  // read path
  // ------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      hfci_pkg::OFS_CONFIG:     rd_mux = config_q;
      hfci_pkg::OFS_EVENT:      rd_mux = {1'b0, ev_flag_q};
      hfci_pkg::OFS_IRQ_EN:     rd_mux = {1'b0, ev_en_q};
      hfci_pkg::OFS_MISC_EVENT: rd_mux[hfci_pkg::BIT_CRC_FLAG] = crc_flag_q;
      hfci_pkg::OFS_MISC_EN:    rd_mux[hfci_pkg::BIT_CRC_FLAG] = crc_en_q;
      hfci_pkg::OFS_FAULT:      rd_mux = fault_img;
      // empty read gives zero, no pop
      hfci_pkg::OFS_BUF_PORT:
        rd_mux = empty ? 8'h00 : mem_q[rp_q[PW-1:0]];
      hfci_pkg::OFS_BUF_COUNT:  rd_mux = {1'b0, count};
      hfci_pkg::OFS_THRESHOLD:  rd_mux = {2'h0, thr_q};
      hfci_pkg::OFS_STATE: begin
        rd_mux[hfci_pkg::BIT_ST_NEAR_E]  = near_e;
        rd_mux[hfci_pkg::BIT_ST_NEAR_F]  = near_f;
        rd_mux[hfci_pkg::BIT_ST_IRQ]     = irq_any;
        rd_mux[hfci_pkg::BIT_ST_CRC_FIN] = crc_fin_q;
      end
      hfci_pkg::OFS_CRC_HI:     rd_mux = crc_q[15:8];
      hfci_pkg::OFS_CRC_LO:     rd_mux = crc_q[7:0];
      hfci_pkg::OFS_LEN_LOW:    rd_mux = {2'h0, len_min_q};
      hfci_pkg::OFS_LEN_HIGH:   rd_mux = {2'h0, len_max_q};
      default:                  rd_mux = 8'h00;
    endcase
  end

  // data stands one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= re ? rd_mux : 8'h00;
    end
  end

  assign rdata    = rdata_q;
  assign pkt_drop = drop_q;
  assign irq      = irq_q;

endmodule : hfci_top

// file: testbench/hfci_props.sv
// pin-level checks for hfci_top
// assumes it is bound to every hfci_top and sees only its ports
module hfci_props #(
  parameter int DEPTH = 64 // buffer entries
) (
  input wire logic               clk,      // clock
  input wire logic               rst,      // reset, high
  input wire logic [3:0]         addr,     // address
  input wire logic [7:0]         wdata,    // write data
  input wire logic               we,       // write strobe
  input wire logic               re,       // read strobe
  input wire logic [7:0]         rdata,    // read data
  input wire hfci_pkg::hfci_ev_s ev,       // core events
  input wire logic [7:0]         fault_in, // error bits
  input wire hfci_pkg::hfci_rx_s rx,       // received bytes
  input wire logic               pkt_drop, // drop pulse
  input wire logic               irq       // irq pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // shadow of limits and enables
  // -----------------------------------------------------------------
  logic [5:0] mn_q;
  logic [5:0] mx_q;
  logic [6:0] en_q;
  logic       me_q;
  // shadow follows host writes, same edge as the design
  always_ff @(posedge clk) begin
    if (rst) begin
      mn_q <= 6'h00;
      mx_q <= 6'h00;
      en_q <= 7'h00;
      me_q <= 1'b0;
    end else if (we) begin
      if (addr == hfci_pkg::OFS_LEN_LOW) mn_q <= wdata[5:0];
      if (addr == hfci_pkg::OFS_LEN_HIGH) mx_q <= wdata[5:0];
      if (addr == hfci_pkg::OFS_IRQ_EN) en_q <= wdata[6:0];
      if (addr == hfci_pkg::OFS_MISC_EN) me_q <= wdata[2];
    end
  end
  // flag clears and enable writes may drop irq, nothing else may
  wire       clr_w = we && (addr == hfci_pkg::OFS_EVENT ||
                    addr == hfci_pkg::OFS_IRQ_EN ||
                    addr == hfci_pkg::OFS_MISC_EVENT ||
                    addr == hfci_pkg::OFS_MISC_EN);
  wire       first_w = rx.valid && rx.first;
  wire [7:0] lo4 = {mn_q, 2'b00};
  wire [7:0] hi4 = {mx_q, 2'b00};
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (we |=> rdata == 8'h00)
    else $error("read data not zero after a write");
  drop_cause_a: assert property (pkt_drop |-> $past(first_w))
    else $error("drop pulse without a length byte");
  len_low_a: assert property (first_w && rx.data < lo4 |=> pkt_drop)
    else $error("short packet not dropped");
  len_high_a: assert property (first_w && mx_q != 6'h00 &&
    rx.data >= hi4 |=> pkt_drop)
    else $error("long packet not dropped");
  len_keep_a: assert property (first_w && rx.data >= lo4 &&
    (mx_q == 6'h00 || rx.data < hi4) |=> !pkt_drop)
    else $error("packet in range dropped");
  timer_irq_a: assert property (ev.timer_zero &&
    en_q[hfci_pkg::EV_TIMER] |-> ##2 irq)
    else $error("countdown event gave no irq");
  send_irq_a: assert property (ev.tx_done &&
    en_q[hfci_pkg::EV_TX] |-> ##2 irq)
    else $error("send done gave no irq");
  idle_irq_a: assert property (ev.cmd_idle &&
    en_q[hfci_pkg::EV_IDLE] |-> ##2 irq)
    else $error("command idle gave no irq");
  rx_irq_a: assert property (rx.done && en_q[hfci_pkg::EV_RX]
    |-> ##2 irq)
    else $error("receive done gave no irq");
  irq_hold_a: assert property (irq && !clr_w && !$past(clr_w)
    |=> irq)
    else $error("irq dropped without a host clear");
  irq_mask_a: assert property ((en_q == 7'h00 && !me_q) [*2]
    |-> !irq)
    else $error("irq high with all enables off");
endmodule : hfci_props

bind hfci_top hfci_props #(.DEPTH(DEPTH)) hfci_props_i (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
  .rdata(rdata), .ev(ev), .fault_in(fault_in), .rx(rx),
  .pkt_drop(pkt_drop), .irq(irq));

// file: testbench/hfci_rx_model.sv
// receiver stand-in feeding packets to the buffer unit
// assumes the bench calls send between its own register accesses
module hfci_rx_model (
  input wire logic           clk, // clock
  output hfci_pkg::hfci_rx_s rx   // received bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx = '0;
  // -----------------------------------------------------------------
  // one packet: length byte, two bytes, end marker
  // -----------------------------------------------------------------
  task automatic send(input logic [7:0] len, input logic [7:0] b0,
                      input logic [7:0] b1, input int gap);
    @(posedge clk);
    rx <= '{1'b1, 1'b1, 1'b0, len}; // length byte leads
    @(posedge clk);
    rx <= '{1'b1, 1'b0, 1'b0, b0};
    // slow sender: idle data keeps changing, never a stale byte
    repeat (gap) begin
      @(posedge clk);
      rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
    end
    @(posedge clk);
    rx <= '{1'b1, 1'b0, 1'b0, b1};
    @(posedge clk);
    rx <= '{1'b0, 1'b0, 1'b1, ~b1}; // end never shares a byte
    @(posedge clk);
    rx <= '{1'b0, 1'b0, 1'b0, b1};
  endtask : send
endmodule : hfci_rx_model

// file: testbench/tb.sv
// self-checking bench for hfci_top: registers, buffer, checksum, screening
// assumes hfci_props is bound and hfci_rx_model drives the receive port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [3:0]         addr = 4'h0;
  logic [7:0]         wdata = 8'h00;
  logic               we = 1'b0;
  logic               re = 1'b0;
  logic [7:0]         rdata;
  hfci_pkg::hfci_ev_s ev = '0;
  logic [7:0]         fault_in = 8'h00;
  hfci_pkg::hfci_rx_s rx;
  logic               pkt_drop;
  logic               irq;
  int                 err_total = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  logic [31:0]        seed = 32'hE1C66E4A;
  logic [15:0]        exp_q[$]; // mask and value of pending reads
  logic               rd_q = 1'b0;
  logic [15:0]        e;
  logic [15:0]        c;
  logic [7:0]         b0;
  logic [7:0]         b1;
  logic [7:0]         buf_m[64];
  logic [15:0]        pre[4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
  logic [7:0]         evb[3] = '{8'h01, 8'h40, 8'h10};
  logic [7:0]         lens[5] = '{8'h0F, 8'h14, 8'h10, 8'h23, 8'hFF};
  always #5 clk = ~clk;
  hfci_top hfci_top_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .ev(ev), .fault_in(fault_in),
    .rx(rx), .pkt_drop(pkt_drop), .irq(irq));
  hfci_rx_model hfci_rx_model_i (.clk(clk), .rx(rx));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // bitwise reference, both feeding orders
  function automatic logic [15:0] crc_step(input logic [15:0] s,
                                           input logic [7:0] d,
                                           input logic m);
    for (int i = 0; i < 8; i++) begin
      if (m) s = (s << 1) ^ ((s[15] ^ d[7-i]) ? 16'h1021 : 16'h0000);
      else s = (s >> 1) ^ ((s[0] ^ d[i]) ? 16'h8408 : 16'h0000);
    end
    return s;
  endfunction : crc_step
  task automatic check(input logic [7:0] seen, input logic [7:0] ex);
    tests_run++;
    if (seen !== ex) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, ex);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] x,
                    input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    exp_q.push_back({m, x & m});
    @(posedge clk);
    re <= 1'b0;
  endtask : rd
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // read data stands one cycle only, so compare at the next edge
  always @(posedge clk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      check(rdata & e[15:8], e[7:0]);
    end
    rd_q <= re;
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(hfci_pkg::OFS_THRESHOLD, 8'h08);
    rd(4'hF, 8'h00);
    rd(hfci_pkg::OFS_EVENT, 8'h04);
    rd(hfci_pkg::OFS_STATE, 8'h01, 8'h13);
    $display("test reset done");
    wr(hfci_pkg::OFS_IRQ_EN, 8'h7F);
    for (int i = 0; i < 3; i++) begin
      wr(hfci_pkg::OFS_EVENT, 8'h7F);
      ev <= hfci_pkg::hfci_ev_s'(3'b100 >> i);
      @(posedge clk);
      ev <= '0;
      repeat (3) @(posedge clk);
      rd(hfci_pkg::OFS_EVENT, evb[i]);
      rd(hfci_pkg::OFS_STATE, 8'h11, 8'h13);
      rd(hfci_pkg::OFS_EVENT, evb[i]);
    end
    wr(hfci_pkg::OFS_EVENT, 8'h7F);
    b0 = (rnd() & 8'hEF) | 8'h01;
    fault_in <= b0;
    repeat (2) @(posedge clk);
    rd(hfci_pkg::OFS_FAULT, b0);
    rd(hfci_pkg::OFS_EVENT, 8'h02, 8'h02);
    fault_in <= 8'h00;
    wr(hfci_pkg::OFS_IRQ_EN, 8'h00);
    $display("test events done");
    for (int i = 0; i < 64; i++) begin
      buf_m[i] = rnd();
      wr(hfci_pkg::OFS_BUF_PORT, buf_m[i]);
    end
    wr(hfci_pkg::OFS_BUF_PORT, 8'hA5);
    rd(hfci_pkg::OFS_BUF_COUNT, 8'h40);
    rd(hfci_pkg::OFS_STATE, 8'h02, 8'h03);
    rd(hfci_pkg::OFS_FAULT, 8'h10);
    rd(hfci_pkg::OFS_EVENT, 8'h08, 8'h08);
    wr(hfci_pkg::OFS_EVENT, 8'h7F);
    wr(hfci_pkg::OFS_IRQ_EN, 8'h04);
    for (int i = 0; i < 64; i++) rd(hfci_pkg::OFS_BUF_PORT, buf_m[i]);
    rd(hfci_pkg::OFS_STATE, 8'h11, 8'h13);
    rd(hfci_pkg::OFS_BUF_COUNT, 8'h00);
    rd(hfci_pkg::OFS_BUF_PORT, 8'h00);
    rd(hfci_pkg::OFS_FAULT, 8'h10);
    wr(hfci_pkg::OFS_BUF_PORT, rnd());
    wr(hfci_pkg::OFS_BUF_COUNT, 8'h80);
    rd(hfci_pkg::OFS_BUF_COUNT, 8'h00);
    rd(hfci_pkg::OFS_FAULT, 8'h00);
    wr(hfci_pkg::OFS_IRQ_EN, 8'h00);
    $display("test buffer done");
    for (int k = 0; k < 4; k++) begin
      wr(hfci_pkg::OFS_CONFIG, {k[0], 5'h00, k[1:0]});
      c = pre[k];
      for (int j = 0; j < 3; j++) begin
        b0 = rnd();
        wr(hfci_pkg::OFS_BUF_PORT, b0);
        c = crc_step(c, b0, k[0]);
      end
      wr(hfci_pkg::OFS_CRC_CTRL, 8'h01);
      repeat (6) @(posedge clk);
      rd(hfci_pkg::OFS_CRC_HI, c[15:8]);
      rd(hfci_pkg::OFS_CRC_LO, c[7:0]);
      rd(hfci_pkg::OFS_STATE, 8'h20, 8'h20);
      rd(hfci_pkg::OFS_MISC_EVENT, 8'h04, 8'h04);
      wr(hfci_pkg::OFS_MISC_EVENT, 8'h04);
    end
    $display("test checksum done");
    wr(hfci_pkg::OFS_IRQ_EN, 8'h20);
    wr(hfci_pkg::OFS_LEN_LOW, 8'h04);
    wr(hfci_pkg::OFS_LEN_HIGH, 8'h05);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) wr(hfci_pkg::OFS_LEN_LOW, 8'h09);
      if (i == 3) wr(hfci_pkg::OFS_LEN_HIGH, 8'h00);
      b0 = rnd();
      b1 = rnd();
      hfci_rx_model_i.send(lens[i], b0, b1, i);
      rd(hfci_pkg::OFS_EVENT, 8'h20, 8'h20);
      wr(hfci_pkg::OFS_EVENT, 8'h7F);
      rd(hfci_pkg::OFS_BUF_COUNT, (i == 2 || i == 4) ? 8'h04 : 8'h00);
      if (i == 2 || i == 4) begin
        rd(hfci_pkg::OFS_BUF_PORT, lens[i]);
        rd(hfci_pkg::OFS_BUF_PORT, b0);
        rd(hfci_pkg::OFS_BUF_PORT, b1);
        rd(hfci_pkg::OFS_BUF_PORT, 8'h00);
      end
    end
    $display("test screening done");
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : tb
